// *** hdl/hsgc_pkg.sv ***
// package: register map, modes and timing for the hsync gated pulse counter
package hsgc_pkg;
  // register file and peripheral addresses
  localparam logic [6:0] RF_GATE_MODE = 7'h11;
  localparam logic [6:0] RF_GATE_STATUS = 7'h12;
  localparam logic [6:0] PA_PULSE_COUNT = 7'h04;
  // field layout
  localparam int CNT_W = 6;
  localparam int MODE_W = 2;
  localparam int STATUS_OPEN_BIT = 3;
  localparam logic [5:0] COUNT_RESET = 6'h00;
  // gate mode encodings
  localparam logic [1:0] MODE_CLOSED = 2'h0;
  localparam logic [1:0] MODE_TIMED = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam int MODE_OPEN_FLAG = 0;
  // timing, clock at 100 MHz; whole nanoseconds keep the half-microsecond delay exact
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMED_DELAY_NS = 1_687_500; // 3.375/2 ms
  localparam int TIMED_OPEN_NS = 1_690_000; // 1.69 ms
  localparam int DELAY_CYC = TIMED_DELAY_NS / CLK_PERIOD_NS;
  localparam int OPEN_CYC = TIMED_OPEN_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 18;
endpackage : hsgc_pkg

// *** hdl/hsgc_counter.sv ***
// file: gated 6-bit hsync pulse counter with gate mode control and status
`timescale 1ns/100ps
`default_nettype none

module hsgc_counter (
  input wire logic CLK, // 100 MHz system clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic CLOCK_STOP, // clock stop event, same domain
  input wire logic SYNC_COUNT_INPUT_PIN, // amplified sync input, async
  input wire logic SHARED_PORT_BIT_IN, // port bit level from pin path
  input wire logic RF_WR, // regfile write instruction strobe
  input wire logic RF_RD, // regfile read instruction strobe
  input wire logic [6:0] RF_ADDR, // regfile address
  input wire logic [3:0] RF_WDATA, // window register data in
  input wire logic PERIPH_RD, // peripheral read instruction strobe
  input wire logic [6:0] PERIPH_ADDR, // peripheral address
  output logic [3:0] RF_RDATA, // data to window register
  output logic [15:0] DATA_BUFFER, // data buffer load value
  output logic DATA_BUFFER_LOAD, // data buffer load pulse
  output logic SHARED_PORT_BIT_READ, // port bit as read by software
  output logic AMP_BIAS_EN, // input amplifier bias enable
  output logic GATE_OPEN // gate state
);

  // timed gate sequencer states, written out one-hot
  typedef enum logic [2:0] {
    seq_idle = 3'h1, // no timed window pending
    seq_delay = 3'h2, // start delay running, gate still shut
    seq_window = 3'h4 // measuring window, gate open
  } hsgc_gate_seq_t;

  // widths of the counting and mode registers
  typedef logic [hsgc_pkg::TMR_W-1:0] hsgc_tmr_t;
  typedef logic [hsgc_pkg::CNT_W-1:0] hsgc_cnt_t;
  typedef logic [hsgc_pkg::MODE_W-1:0] hsgc_mode_t;

  // last timer value of each phase; the timer counts up from zero
  // the start delay takes no added error, the low end of what is allowed
  localparam hsgc_tmr_t delay_last = hsgc_tmr_t'(hsgc_pkg::DELAY_CYC - 1);
  localparam hsgc_tmr_t window_last = hsgc_tmr_t'(hsgc_pkg::OPEN_CYC - 1);

  // strobe qualified by an address match, shared by every decoder
  function automatic logic addr_hit(
    input logic strobe,
    input logic [6:0] addr,
    input logic [6:0] target
  );
    addr_hit = strobe && (addr == target);
  endfunction

  // modes other than closed bias the input and take over the pin
  function automatic logic mode_biased(input hsgc_mode_t mode);
    mode_biased = (mode != hsgc_pkg::MODE_CLOSED);
  endfunction

  // input synchroniser and edge detector
  logic sync_ff1;
  logic sync_ff2;
  logic sync_prev;
  logic sync_rise;

  // gate mode flags and timed sequencer
  hsgc_mode_t gate_mode_control;
  hsgc_gate_seq_t seq;
  hsgc_gate_seq_t next_seq;
  hsgc_tmr_t tmr;
  hsgc_tmr_t next_tmr;

  // access decode
  logic mode_wr;
  logic wr_open;
  logic wr_timed;
  logic rd_mode;
  logic rd_status;
  logic rd_count;

  // gate, counting and status
  logic gate;
  logic gate_edge;
  logic pulse;
  logic clr;
  hsgc_cnt_t sync_pulse_count;
  hsgc_cnt_t next_count;
  logic [3:0] status_word;

  // two-stage synchroniser on the pin; stage one is read only by stage two
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sync_ff1 <= 1'h0;
      sync_ff2 <= 1'h0;
    end
    else
    begin
      sync_ff1 <= SYNC_COUNT_INPUT_PIN;
      sync_ff2 <= sync_ff1;
    end
  end

  // previous synchronised level; reset low to match the idle pin
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      sync_prev <= 1'h0;
    else
      sync_prev <= sync_ff2;
  end

  // one count request per rising edge of the synchronised input
  assign sync_rise = sync_ff2 && !sync_prev;

  // clock stop acts as a reset of mode, sequencer and count
  // a stop in mid-window discards the measurement, software must restart it
  assign clr = !RST_N || CLOCK_STOP;

  // register file and peripheral decode
  assign mode_wr = addr_hit(RF_WR, RF_ADDR, hsgc_pkg::RF_GATE_MODE);
  assign wr_timed = mode_wr && (RF_WDATA[hsgc_pkg::MODE_W-1:0] == hsgc_pkg::MODE_TIMED);
  assign wr_open = mode_wr && RF_WDATA[hsgc_pkg::MODE_OPEN_FLAG];
  assign rd_mode = addr_hit(RF_RD, RF_ADDR, hsgc_pkg::RF_GATE_MODE);
  assign rd_status = addr_hit(RF_RD, RF_ADDR, hsgc_pkg::RF_GATE_STATUS);
  assign rd_count = addr_hit(PERIPH_RD, PERIPH_ADDR, hsgc_pkg::PA_PULSE_COUNT);

  // gate mode flags, written through the window register only
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      gate_mode_control <= hsgc_pkg::MODE_RESET;
    end
    else if (mode_wr)
    begin
      gate_mode_control <= RF_WDATA[hsgc_pkg::MODE_W-1:0];
    end
  end

  // sequencer next state; any other mode write cancels a timed run
  always_comb
  begin
    next_seq = seq;
    if (wr_timed)
      next_seq = seq_delay;
    else if (mode_wr)
      next_seq = seq_idle;
    else
    begin
      case (seq)
        seq_idle:
          next_seq = seq_idle;
        seq_delay:
        begin
          if (tmr == delay_last)
            next_seq = seq_window;
        end
        seq_window:
        begin
          if (tmr == window_last)
            next_seq = seq_idle;
        end
        default:
          next_seq = seq_idle;
      endcase
    end
  end

  // sequencer state register
  always_ff @(posedge CLK)
  begin
    if (clr)
      seq <= seq_idle;
    else
      seq <= next_seq;
  end

  // gate clock timer, idle outside timed runs
  // one timer serves both phases, so it restarts at every phase change
  always_comb
  begin
    next_tmr = tmr + 18'h00001;
    if (mode_wr || (next_seq != seq) || (seq == seq_idle))
      next_tmr = '0;
  end

  // timer register
  always_ff @(posedge CLK)
  begin
    if (clr)
      tmr <= '0;
    else
      tmr <= next_tmr;
  end

  // gate: open flag set (modes 1 and 3) or the timed window running
  assign gate = gate_mode_control[hsgc_pkg::MODE_OPEN_FLAG] || (seq == seq_window);

  // a high input at the instant the gate opens or closes counts once
  assign gate_edge = (gate != GATE_OPEN) && sync_ff2;
  // a rising edge in the cycle of a gate change still counts only once
  assign pulse = (gate && sync_rise) || gate_edge;

  // next count wraps through zero by plain binary overflow
  always_comb
  begin
    next_count = sync_pulse_count + 6'h01;
  end

  // pulse counter: cleared on entry to a counting mode, held when shut
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      sync_pulse_count <= hsgc_pkg::COUNT_RESET;
    end
    else if (wr_timed || wr_open)
    begin
      sync_pulse_count <= hsgc_pkg::COUNT_RESET;
    end
    else if (pulse)
    begin
      sync_pulse_count <= next_count;
    end
    // no else: held while gate is shut
  end

  // status word: open bit high while the gate is open or a timed run is pending
  always_comb
  begin
    status_word = 4'h0;
    status_word[hsgc_pkg::STATUS_OPEN_BIT] = gate || (seq == seq_delay);
  end

  // registered gate state, also the reference for gate-edge counting
  always_ff @(posedge CLK)
  begin
    if (clr)
      GATE_OPEN <= 1'h0;
    else
      GATE_OPEN <= gate;
  end

  // amplifier bias follows the mode, not the gate
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      AMP_BIAS_EN <= 1'h0;
    end
    else
    begin
      AMP_BIAS_EN <= mode_biased(gate_mode_control);
    end
  end

  // port bit masked while the pin feeds the counter
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      SHARED_PORT_BIT_READ <= 1'h0;
    end
    else if (mode_biased(gate_mode_control))
    begin
      SHARED_PORT_BIT_READ <= 1'h0;
    end
    else
    begin
      SHARED_PORT_BIT_READ <= SHARED_PORT_BIT_IN;
    end
  end

  // register file reads, answered the cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      RF_RDATA <= 4'h0;
    end
    else if (rd_mode)
    begin
      RF_RDATA <= {2'h0, gate_mode_control};
    end
    else if (rd_status)
    begin
      RF_RDATA <= status_word;
    end
    else
    begin
      RF_RDATA <= 4'h0;
    end
  end

  // data buffer load pulse for a read of the counter
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      DATA_BUFFER_LOAD <= 1'h0;
    end
    else
    begin
      DATA_BUFFER_LOAD <= rd_count;
    end
  end

  // data buffer value; the counter has no write path
  always_ff @(posedge CLK)
  begin
    if (clr)
    begin
      DATA_BUFFER <= 16'h0000;
    end
    else
    begin
      DATA_BUFFER <= {10'h000, sync_pulse_count};
    end
  end

endmodule // hsgc_counter

`default_nettype wire

// *** tb/hsgc_sync_src.sv ***
// sync pulse source standing in for the video circuitry
`timescale 1ns/100ps
`default_nettype none
module hsgc_sync_src (
  output var logic PIN // sync level, low between pulses
);
  initial PIN = 1'b0;
  // free of the system clock on purpose, so the input sync sees real skew
  task automatic pulses(input int n);
    repeat (n)
    begin
      #40 PIN = 1'b1;
      #60 PIN = 1'b0;
    end
  endtask
  // hold the line at one level, for gate-edge cases
  task automatic level(input logic lvl);
    PIN = lvl;
  endtask
endmodule // hsgc_sync_src
`default_nettype wire

// *** tb/hsgc_counter_sva.sv ***
// checker: port-level properties of the gated sync counter
`timescale 1ns/100ps
`default_nettype none
module hsgc_counter_chk (
  input wire logic CLK, RST_N, CLOCK_STOP, RF_WR, RF_RD, PERIPH_RD, // strobes
  input wire logic [6:0] RF_ADDR, PERIPH_ADDR, // addresses
  input wire logic [3:0] RF_WDATA, RF_RDATA, // regfile data
  input wire logic [15:0] DATA_BUFFER, // buffer value
  input wire logic DATA_BUFFER_LOAD, SHARED_PORT_BIT_READ, AMP_BIAS_EN, GATE_OPEN // state
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // mode writes decoded once
  logic wr_mode;
  assign wr_mode = RF_WR && RF_ADDR == hsgc_pkg::RF_GATE_MODE;
  property p_rd_idle; !$past(RF_RD) |-> RF_RDATA == 4'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_load;
    DATA_BUFFER_LOAD == $past(PERIPH_RD && PERIPH_ADDR == hsgc_pkg::PA_PULSE_COUNT);
  endproperty
  a_load: assert property (p_load) else $error("buffer load wrong");
  property p_width; DATA_BUFFER[15:6] == 10'h000; endproperty
  a_width: assert property (p_width) else $error("count wider than six bits");
  property p_bias_on; wr_mode && RF_WDATA[1:0] != 2'h0 |-> ##[1:2] AMP_BIAS_EN; endproperty
  a_bias_on: assert property (p_bias_on) else $error("no bias in counting mode");
  property p_bias_off; wr_mode && RF_WDATA[1:0] == 2'h0 |-> ##[1:2] !AMP_BIAS_EN; endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias left on");
  property p_port_zero; AMP_BIAS_EN && $past(AMP_BIAS_EN) |-> !SHARED_PORT_BIT_READ; endproperty
  a_port_zero: assert property (p_port_zero) else $error("port bit not zero");
  // clock stop also clears the count, so it is kept out of the window
  property p_hold; (!AMP_BIAS_EN && !CLOCK_STOP)[*3] |-> $stable(DATA_BUFFER); endproperty
  a_hold: assert property (p_hold) else $error("count moved while closed");
  property p_stop;
    CLOCK_STOP |-> ##3 (!AMP_BIAS_EN && !GATE_OPEN && DATA_BUFFER[5:0] == 6'h00);
  endproperty
  a_stop: assert property (p_stop) else $error("clock stop not obeyed");
  property p_open; wr_mode && RF_WDATA[0] |-> ##[1:3] GATE_OPEN; endproperty
  a_open: assert property (p_open) else $error("gate did not open");
endmodule // hsgc_counter_chk
bind hsgc_counter hsgc_counter_chk i_chk (.CLK(CLK), .RST_N(RST_N), .CLOCK_STOP(CLOCK_STOP),
  .RF_WR(RF_WR), .RF_RD(RF_RD), .PERIPH_RD(PERIPH_RD), .RF_ADDR(RF_ADDR),
  .PERIPH_ADDR(PERIPH_ADDR), .RF_WDATA(RF_WDATA), .RF_RDATA(RF_RDATA),
  .DATA_BUFFER(DATA_BUFFER), .DATA_BUFFER_LOAD(DATA_BUFFER_LOAD),
  .SHARED_PORT_BIT_READ(SHARED_PORT_BIT_READ), .AMP_BIAS_EN(AMP_BIAS_EN), .GATE_OPEN(GATE_OPEN));
`default_nettype wire

// *** tb/hsgc_counter_tb.sv ***
// testbench: mode, status and count checks through the access strobes
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module hsgc_counter_tb;
  logic clk, rst_n, stop, wr, rd, prd, pin_in, load, port_rd, bias, gate;
  logic [6:0] addr, paddr;
  logic [3:0] wdata, rdata, v;
  logic [15:0] dbuf;
  wire pin;
  int miscompares, cmp_count, cycles;
  hsgc_sync_src i_hsgc_sync_src (.PIN(pin));
  hsgc_counter i_hsgc_counter (.CLK(clk), .RST_N(rst_n), .CLOCK_STOP(stop),
    .SYNC_COUNT_INPUT_PIN(pin), .SHARED_PORT_BIT_IN(pin_in), .RF_WR(wr), .RF_RD(rd),
    .RF_ADDR(addr), .RF_WDATA(wdata), .PERIPH_RD(prd), .PERIPH_ADDR(paddr),
    .RF_RDATA(rdata), .DATA_BUFFER(dbuf), .DATA_BUFFER_LOAD(load),
    .SHARED_PORT_BIT_READ(port_rd), .AMP_BIAS_EN(bias), .GATE_OPEN(gate));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, the whole run needs well under two thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // one strobe cycle per access, answer sampled just after the taking edge
  task automatic rf_io(input logic w, input logic [6:0] a, input logic [3:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk_cnt(input logic [5:0] e);
    @(posedge clk);
    prd <= 1'b1;
    paddr <= hsgc_pkg::PA_PULSE_COUNT;
    @(posedge clk);
    prd <= 1'b0;
    #1 `CHK({load, dbuf[5:0]}, {1'b1, e})
  endtask
  initial
  begin
    {rst_n, stop, wr, rd, prd, addr, paddr, wdata} = '0;
    pin_in = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rf_io(0, hsgc_pkg::RF_GATE_MODE, 0); `CHK(v, 4'h0)
    chk_cnt(6'h00);
    `CHK(port_rd, 1'b1)
    $display("reset test done");
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h1);
    rf_io(0, hsgc_pkg::RF_GATE_MODE, 0); `CHK(v, 4'h1)
    rf_io(0, hsgc_pkg::RF_GATE_STATUS, 0); `CHK(v[3], 1'b1)
    `CHK({bias, port_rd}, 2'b10)
    i_hsgc_sync_src.pulses(70);
    repeat (5) @(posedge clk);
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h0);
    repeat (3) @(posedge clk);
    #1 `CHK({bias, gate}, 2'h0)
    chk_cnt(6'h06);
    i_hsgc_sync_src.pulses(3);
    chk_cnt(6'h06);
    rf_io(0, hsgc_pkg::RF_GATE_STATUS, 0); `CHK(v[3], 1'b0)
    $display("open test done");
    i_hsgc_sync_src.level(1'h1);
    repeat (4) @(posedge clk);
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h1);
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h0);
    i_hsgc_sync_src.level(1'h0);
    chk_cnt(6'h02);
    $display("gate edge test done");
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h3);
    chk_cnt(6'h00);
    i_hsgc_sync_src.pulses(2);
    chk_cnt(6'h02);
    rf_io(0, 7'h13, 4'h0); `CHK(v, 4'h0)
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h0);
    rf_io(0, hsgc_pkg::RF_GATE_STATUS, 4'h0); `CHK(v[3], 1'h0)
    rf_io(1, hsgc_pkg::RF_GATE_MODE, {2'h0, hsgc_pkg::MODE_TIMED});
    rf_io(0, hsgc_pkg::RF_GATE_STATUS, 4'h0); `CHK(v[3], 1'h1)
    chk_cnt(6'h00);
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h1);
    i_hsgc_sync_src.pulses(2);
    chk_cnt(6'h02);
    @(posedge clk) stop <= 1'h1;
    @(posedge clk) stop <= 1'h0;
    repeat (3) @(posedge clk);
    rf_io(0, hsgc_pkg::RF_GATE_MODE, 4'h0); `CHK(v, 4'h0)
    chk_cnt(6'h00);
    rf_io(1, hsgc_pkg::RF_GATE_MODE, 4'h1);
    @(posedge clk) rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rf_io(0, hsgc_pkg::RF_GATE_MODE, 4'h0); `CHK(v, 4'h0)
    #1 `CHK(bias, 1'h0)
    $display("timed, stop and reset test done");
    report_and_stop();
  end
endmodule // hsgc_counter_tb
`default_nettype wire
